/* inc/rfstq_consts.svh */
// rfstq_consts.svh: offsets, bit positions and reset values of the
// receive status / transmit enqueue register bank.
// assumes it is included once per unit by its bare name.
`ifndef RFSTQ_CONSTS_SVH
`define RFSTQ_CONSTS_SVH

// byte offsets on the host bus (16-bit registers, even addresses)
`define RFSTQ_OFS_RX_STATUS   12'h17c
`define RFSTQ_OFS_RX_BYTES    12'h17e
`define RFSTQ_OFS_TX_CMD      12'h180

// rx_frame_header_status bit positions
`define RFSTQ_B_FRAME_VALID   15
`define RFSTQ_B_ICMP_BAD      13
`define RFSTQ_B_IP_BAD        12
`define RFSTQ_B_TCP_BAD       11
`define RFSTQ_B_UDP_BAD       10
`define RFSTQ_B_BCAST         7
`define RFSTQ_B_MCAST         6
`define RFSTQ_B_UCAST         5
`define RFSTQ_B_ETHTYPE       3
`define RFSTQ_B_RUNT          1
`define RFSTQ_B_CRC_ERR       0

// tx_queue_command bit positions and reset value
`define RFSTQ_B_SPACE_MON     1
`define RFSTQ_B_MAN_ENQ       0
`define RFSTQ_TX_CMD_RST      2'h0

// length/type values above this mark an ethernet-type frame
`define RFSTQ_ETHTYPE_MIN     16'h05dc
// group bit of the destination address (first octet, lsb)
`define RFSTQ_GROUP_BIT       40

`endif

/* inc/rfstq_pkg.sv */
// rfstq_pkg: types shared by the register bank and its bench.
// assumes nothing beyond a systemverilog compiler.
`default_nettype none

package rfstq_pkg;

    // host bus request, synchronous to clk
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } rfstq_host_req_t;

    // head frame of the receive queue as the receive path reports it
    typedef struct packed {
        logic        icmp_bad;
        logic        ip_bad;
        logic        tcp_bad;
        logic        udp_bad;
        logic        runt;
        logic        crc_err;
        logic [47:0] dest_mac;
        logic [15:0] len_type;
        logic [11:0] byte_size;
    } rfstq_rx_head_t;

    // presentation of the head frame
    typedef enum logic [2:0] {
        RFSTQ_EMPTY = 3'h1,
        RFSTQ_SHOW  = 3'h2,
        RFSTQ_DROP  = 3'h4
    } rfstq_rx_state_t;

endpackage

`default_nettype wire

/* verilog/rfstq_regs.sv */
// rfstq_regs: host-visible receive frame status, receive byte count
// and transmit queue command registers of the processor port.
// assumes the host bus and the queue signals are all on clk; the
// receive path holds the head frame stable while head_valid is high.
`include "rfstq_consts.svh"
`default_nettype none

module rfstq_regs
(
    // clock, reset, enable
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   ce,
    // host bus
    input  wire rfstq_pkg::rfstq_host_req_t host_req,
    output logic [15:0]                 host_rdata,
    output logic                        host_rvalid,
    // receive queue head
    input  wire logic                   rxq_head_valid,
    input  wire rfstq_pkg::rfstq_rx_head_t rxq_head,
    input  wire logic                   pass_bad_frame,
    output logic                        rxq_drop,
    // transmit queue
    input  wire logic [12:0]            tx_free_bytes,
    input  wire logic [12:0]            tx_space_request,
    input  wire logic                   tx_frame_done,
    output logic                        txq_enqueue,
    output logic                        tx_space_event,
    output logic [1:0]                  tx_cmd_bits
);

    // hazards a user of this bank must know:
    // - the host bus is taken as synchronous to clk; a host on its own
    //   clock needs a bridge in front of this port
    // - status and count are captured once per frame, so a receive path
    //   that changes the head frame without dropping head_valid first
    //   goes unnoticed until head_valid falls
    // - an 8-bit host that reads the high count byte without the low
    //   byte first gets the nibble of an earlier frame
    // - a command write of 1 while the bit is still set is absorbed; it
    //   neither queues a second frame nor re-arms the monitor
    // - ce low freezes every register, the read answer included

    // decoded accesses
    logic                       rd_status;
    logic                       rd_bytes;
    logic                       wr_cmd;
    logic                       rd_cmd;

    // receive presentation
    rfstq_pkg::rfstq_rx_state_t rx_st_r;
    rfstq_pkg::rfstq_rx_state_t rx_st_nxt;
    logic [15:0]                status_r;
    logic [15:0]                status_nxt;
    logic [11:0]                bytes_r;
    logic [3:0]                 bytes_hi_snap_r;
    logic                       head_bad;

    // transmit command
    logic                       enq_r;
    logic                       mon_r;
    logic                       mon_fired_r;
    logic                       space_ok;

    // read data path
    logic [15:0]                rdata_r;
    logic                       rvalid_r;
    logic                       drop_r;
    logic                       enq_pulse_r;
    logic                       event_r;

    // true when a host access hits the 16-bit word at ofs
    function automatic logic hits(input logic [11:0] addr,
                                  input logic [11:0] ofs);
        hits = (addr[11:1] == ofs[11:1]);
    endfunction

    // merge the enabled byte lanes into a read word
    function automatic logic [15:0] lanes(input logic [15:0] w,
                                          input logic [1:0]  be);
        lanes = {(be[1] ? w[15:8] : 8'h00), (be[0] ? w[7:0] : 8'h00)};
    endfunction

    // one reset bit of the command word; both command bits use it,
    // so the reset value is kept in a single place
    function automatic logic cmd_rst_bit(input int pos);
        logic [1:0] rst_word;
        rst_word    = `RFSTQ_TX_CMD_RST;
        cmd_rst_bit = rst_word[pos];
    endfunction

    // address decode; writes to the read-only words decode to nothing.
    // only the low lane carries command bits, so a high-lane-only
    // write to the command word is dropped as well
    assign rd_status = host_req.rd && hits(host_req.addr,
                                           `RFSTQ_OFS_RX_STATUS);
    assign rd_bytes  = host_req.rd && hits(host_req.addr,
                                           `RFSTQ_OFS_RX_BYTES);
    assign rd_cmd    = host_req.rd && hits(host_req.addr,
                                           `RFSTQ_OFS_TX_CMD);
    assign wr_cmd    = host_req.wr && host_req.be[0]
                       && hits(host_req.addr, `RFSTQ_OFS_TX_CMD);

    // runt and crc frames are the bad ones the host may not see
    assign head_bad = rxq_head.runt || rxq_head.crc_err;

    // status word built from the head frame, valid bit always set here
    always_comb
    begin
        status_nxt = 16'h0000;
        status_nxt[`RFSTQ_B_ICMP_BAD] = rxq_head.icmp_bad;
        status_nxt[`RFSTQ_B_IP_BAD]   = rxq_head.ip_bad;
        status_nxt[`RFSTQ_B_TCP_BAD]  = rxq_head.tcp_bad;
        status_nxt[`RFSTQ_B_UDP_BAD]  = rxq_head.udp_bad;
        status_nxt[`RFSTQ_B_BCAST]    =
            (rxq_head.dest_mac == 48'hffffffffffff);
        status_nxt[`RFSTQ_B_MCAST]    =
            rxq_head.dest_mac[`RFSTQ_GROUP_BIT];
        status_nxt[`RFSTQ_B_UCAST]    =
            !rxq_head.dest_mac[`RFSTQ_GROUP_BIT];
        status_nxt[`RFSTQ_B_ETHTYPE]  =
            (rxq_head.len_type > `RFSTQ_ETHTYPE_MIN);
        status_nxt[`RFSTQ_B_RUNT]     = rxq_head.runt;
        status_nxt[`RFSTQ_B_CRC_ERR]  = rxq_head.crc_err;
        status_nxt[`RFSTQ_B_FRAME_VALID] = 1'b1;
    end

    // next presentation state
    always_comb
    begin
        rx_st_nxt = rx_st_r;
        case (rx_st_r)
            rfstq_pkg::RFSTQ_EMPTY:
            begin
                if (rxq_head_valid && head_bad && !pass_bad_frame)
                    rx_st_nxt = rfstq_pkg::RFSTQ_DROP;
                else if (rxq_head_valid)
                    rx_st_nxt = rfstq_pkg::RFSTQ_SHOW;
            end
            rfstq_pkg::RFSTQ_SHOW:
            begin
                if (!rxq_head_valid)
                    rx_st_nxt = rfstq_pkg::RFSTQ_EMPTY;
            end
            rfstq_pkg::RFSTQ_DROP:
            begin
                // wait for the queue to let go of the dropped frame
                if (!rxq_head_valid)
                    rx_st_nxt = rfstq_pkg::RFSTQ_EMPTY;
            end
            default:
                rx_st_nxt = rfstq_pkg::RFSTQ_EMPTY;
        endcase
    end

    // presentation state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rx_st_r <= rfstq_pkg::RFSTQ_EMPTY;
        else if (ce)
            rx_st_r <= rx_st_nxt;
    end

    // status and count are captured once, when the frame is shown,
    // so the host sees a stable pair even if the head inputs wander
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            status_r <= 16'h0000;
            bytes_r  <= 12'h000;
        end
        else if (ce)
        begin
            if (rx_st_r == rfstq_pkg::RFSTQ_EMPTY
                && rx_st_nxt == rfstq_pkg::RFSTQ_SHOW)
            begin
                status_r <= status_nxt;
                bytes_r  <= rxq_head.byte_size;
            end
            else if (rx_st_nxt != rfstq_pkg::RFSTQ_SHOW)
            begin
                status_r <= 16'h0000;
                bytes_r  <= 12'h000;
            end
        end
    end

    // one drop pulse per withheld frame
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            drop_r <= 1'b0;
        else if (ce)
            drop_r <= (rx_st_r == rfstq_pkg::RFSTQ_EMPTY)
                      && (rx_st_nxt == rfstq_pkg::RFSTQ_DROP);
    end

    // a low-byte-only read freezes the high nibble, so an 8-bit host
    // reading low then high gets one coherent count
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            bytes_hi_snap_r <= 4'h0;
        else if (ce && rd_bytes && host_req.be == 2'b01)
            bytes_hi_snap_r <= bytes_r[11:8];
    end

    // free space meets the request from the host
    assign space_ok = (tx_free_bytes >= tx_space_request);

    // manual enqueue bit: set by a write of 1, cleared when the
    // frame is out; a write landing with done keeps the bit set
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            enq_r <= cmd_rst_bit(`RFSTQ_B_MAN_ENQ);
        else if (ce)
        begin
            if (wr_cmd && host_req.wdata[`RFSTQ_B_MAN_ENQ])
                enq_r <= 1'b1;
            else if (tx_frame_done)
                enq_r <= 1'b0;
        end
    end

    // one enqueue pulse per accepted command; a write while the bit
    // is still set asks for nothing new
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            enq_pulse_r <= 1'b0;
        else if (ce)
            enq_pulse_r <= wr_cmd && !enq_r
                           && host_req.wdata[`RFSTQ_B_MAN_ENQ];
    end

    // memory-available monitor bit, same set-over-clear order
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mon_r <= cmd_rst_bit(`RFSTQ_B_SPACE_MON);
        else if (ce)
        begin
            if (wr_cmd && host_req.wdata[`RFSTQ_B_SPACE_MON])
                mon_r <= 1'b1;
            else if (tx_frame_done)
                mon_r <= 1'b0;
        end
    end

    // the space event fires once per arming of the monitor, not on
    // every cycle the room stays available
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mon_fired_r <= 1'b0;
        else if (ce)
        begin
            if (wr_cmd && host_req.wdata[`RFSTQ_B_SPACE_MON] && !mon_r)
                mon_fired_r <= 1'b0;
            else if (mon_r && space_ok)
                mon_fired_r <= 1'b1;
        end
    end

    // space event pulse toward the interrupt status logic
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            event_r <= 1'b0;
        else if (ce)
            event_r <= mon_r && space_ok && !mon_fired_r;
    end

    // registered read data; unmapped words and reserved bits read 0.
    // the answer is a flop rather than a mux so the host sees a value
    // that does not ripple with the head inputs during the cycle;
    // the price is one cycle of read latency on every access
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
        end
        else if (ce)
        begin
            rvalid_r <= host_req.rd;
            if (rd_status)
                rdata_r <= lanes(status_r, host_req.be);
            else if (rd_bytes && host_req.be == 2'b10)
                rdata_r <= {4'h0, bytes_hi_snap_r, 8'h00};
            else if (rd_bytes)
                rdata_r <= lanes({4'h0, bytes_r},
                                 host_req.be);
            else if (rd_cmd)
                rdata_r <= lanes({14'h0000, mon_r, enq_r},
                                 host_req.be);
            else
                rdata_r <= 16'h0000;
        end
    end

    // outputs
    assign host_rdata     = rdata_r;
    assign host_rvalid    = rvalid_r;
    assign rxq_drop       = drop_r;
    assign txq_enqueue    = enq_pulse_r;
    assign tx_space_event = event_r;
    assign tx_cmd_bits    = {mon_r, enq_r};

endmodule

`default_nettype wire

/* dv/rfstq_regs_properties.sv */
// rfstq_regs_chk: port-level properties of the register bank.
// assumes one clock domain and ce high whenever requests are made.
`default_nettype none

module rfstq_regs_chk
(
    // clock, reset, enable
    input wire logic                       clk,
    input wire logic                       nrst,
    input wire logic                       ce,
    // host bus
    input wire rfstq_pkg::rfstq_host_req_t host_req,
    input wire logic [15:0]                host_rdata,
    input wire logic                       host_rvalid,
    // receive queue head
    input wire logic                       rxq_head_valid,
    input wire rfstq_pkg::rfstq_rx_head_t  rxq_head,
    input wire logic                       pass_bad_frame,
    input wire logic                       rxq_drop,
    // transmit queue
    input wire logic [12:0]                tx_free_bytes,
    input wire logic [12:0]                tx_space_request,
    input wire logic                       tx_frame_done,
    input wire logic                       txq_enqueue,
    input wire logic                       tx_space_event,
    input wire logic [1:0]                 tx_cmd_bits
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic        bad_q;
    logic        ok_q;
    logic [11:0] ofs_q;

    // remember the cause of each registered answer
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            bad_q <= 1'b0;
            ok_q  <= 1'b0;
            ofs_q <= 12'h000;
        end
        else if (ce)
        begin
            bad_q <= rxq_head_valid && !pass_bad_frame
                     && (rxq_head.runt || rxq_head.crc_err);
            ok_q  <= tx_cmd_bits[1] && tx_free_bytes >= tx_space_request;
            ofs_q <= host_req.addr;
        end

    property p_rvalid;
        ce && host_req.rd |=> host_rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read not answered next cycle");
    property p_enq;
        ce && host_req.wr && host_req.addr[11:1] == 11'h0c0
        && host_req.be[0] && host_req.wdata[0] |=> tx_cmd_bits[0];
    endproperty
    a_enq: assert property (p_enq)
        else $error("enqueue write not taken");
    property p_enq_once;
        txq_enqueue |-> tx_cmd_bits[0] && !$past(tx_cmd_bits[0]);
    endproperty
    a_enq_once: assert property (p_enq_once)
        else $error("enqueue pulse without new command");
    property p_done_clr;
        ce && tx_frame_done && !host_req.wr |=> tx_cmd_bits == 2'h0;
    endproperty
    a_done_clr: assert property (p_done_clr)
        else $error("command bits not cleared by done");
    property p_space_evt;
        tx_space_event |-> ok_q ##1 !tx_space_event;
    endproperty
    a_space_evt: assert property (p_space_evt)
        else $error("space event without room or armed");
    property p_drop;
        rxq_drop |-> bad_q;
    endproperty
    a_drop: assert property (p_drop)
        else $error("good frame withheld");
    property p_stat_rsvd;
        host_rvalid && ofs_q[11:1] == 11'h0be
        |-> (host_rdata & 16'h4314) == 16'h0000;
    endproperty
    a_stat_rsvd: assert property (p_stat_rsvd)
        else $error("reserved status bits set");
    property p_cnt_rsvd;
        host_rvalid && ofs_q[11:1] == 11'h0bf |-> host_rdata[15:12] == 4'h0;
    endproperty
    a_cnt_rsvd: assert property (p_cnt_rsvd)
        else $error("byte count upper bits set");
    property p_valid_bit;
        host_rvalid && ofs_q[11:1] == 11'h0be && host_rdata != 16'h0000
        |-> host_rdata[15];
    endproperty
    a_valid_bit: assert property (p_valid_bit)
        else $error("status shown without frame valid");

    c_drop: cover property (rxq_drop);
    c_evt: cover property (tx_space_event);
    c_enq: cover property (txq_enqueue ##[1:20] tx_frame_done);
endmodule

bind rfstq_regs rfstq_regs_chk u_chk (.clk(clk), .nrst(nrst), .ce(ce),
    .host_req(host_req), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .rxq_head_valid(rxq_head_valid),
    .rxq_head(rxq_head), .pass_bad_frame(pass_bad_frame),
    .rxq_drop(rxq_drop), .tx_free_bytes(tx_free_bytes),
    .tx_space_request(tx_space_request), .tx_frame_done(tx_frame_done),
    .txq_enqueue(txq_enqueue), .tx_space_event(tx_space_event),
    .tx_cmd_bits(tx_cmd_bits));

`default_nettype wire

/* dv/rfstq_far_model.sv */
// rfstq_far_model: receive path and transmit queue beside the bank.
// assumes the bench says when a frame is present and what it holds.
`default_nettype none

module rfstq_far_model
#(
    parameter int DONE_DLY = 8
)
(
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      nrst,
    // bench control
    input  wire logic                      present,
    input  wire rfstq_pkg::rfstq_rx_head_t frame,
    // bank side
    input  wire logic                      rxq_drop,
    input  wire logic                      txq_enqueue,
    output logic                           rxq_head_valid,
    output rfstq_pkg::rfstq_rx_head_t      rxq_head,
    output logic                           tx_frame_done
);
    logic dropped_r;
    int   cnt_r;

    // a withheld frame is discarded until the bench withdraws it
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            dropped_r <= 1'b0;
        else if (!present)
            dropped_r <= 1'b0;
        else if (rxq_drop)
            dropped_r <= 1'b1;
    assign rxq_head_valid = present && !dropped_r;
    // released head shows the inverse so stale data never looks right
    assign rxq_head = rxq_head_valid ? frame : ~frame;
    // transmission ends a fixed time after each enqueue
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            cnt_r <= 0;
        else if (txq_enqueue)
            cnt_r <= DONE_DLY;
        else if (cnt_r != 0)
            cnt_r <= cnt_r - 1;
    assign tx_frame_done = (cnt_r == 1);
endmodule

`default_nettype wire

/* dv/rfstq_regs_tb_top.sv */
// rfstq_regs_tb_top: directed bench of the status and command registers.
// assumes the far model stands in for receive path and transmit queue.
`include "rfstq_consts.svh"
`default_nettype none

module rfstq_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                       clk = 1'b0;
    logic                       nrst = 1'b0;
    logic                       present = 1'b0;
    logic                       pass_bad = 1'b0;
    logic                       ce_i = 1'b1;
    logic [12:0]                free_b = 13'h0000;
    logic [12:0]                req_b = 13'h0000;
    rfstq_pkg::rfstq_host_req_t req = '0;
    rfstq_pkg::rfstq_rx_head_t  frame = '0;
    rfstq_pkg::rfstq_rx_head_t  head;
    rfstq_pkg::rfstq_rx_head_t  fr[5];
    logic [15:0]                st[5];
    logic [11:0]                bc[5];
    logic [4:0]                 pb = 5'b10100;
    logic [15:0]                rdata;
    logic                       rvalid, head_v, drop, done, enq, evt;
    logic [1:0]                 cmd;
    int                         fails = 0;
    int                         cmp_count = 0;
    int                         n_enq = 0;
    int                         n_evt = 0;

    rfstq_regs uut (.clk(clk), .nrst(nrst), .ce(ce_i), .host_req(req),
        .host_rdata(rdata), .host_rvalid(rvalid), .rxq_head_valid(head_v),
        .rxq_head(head), .pass_bad_frame(pass_bad), .rxq_drop(drop),
        .tx_free_bytes(free_b), .tx_space_request(req_b),
        .tx_frame_done(done), .txq_enqueue(enq), .tx_space_event(evt),
        .tx_cmd_bits(cmd));
    rfstq_far_model far (.clk(clk), .nrst(nrst), .present(present),
        .frame(frame), .rxq_drop(drop), .txq_enqueue(enq),
        .rxq_head_valid(head_v), .rxq_head(head), .tx_frame_done(done));

    always #20 clk = ~clk;
    // pulses are counted at the edge after they appear
    always @(posedge clk)
        if (enq === 1'b1)
            n_enq++;
    always @(posedge clk)
        if (evt === 1'b1)
            n_evt++;

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one-cycle read, answer looked at while it stands
    task automatic rd(input logic [11:0] a, input logic [1:0] be,
                      input logic [15:0] exp, input string nm);
        @(negedge clk);
        req.rd   = 1'b1;
        req.addr = a;
        req.be   = be;
        @(negedge clk);
        req.rd = 1'b0;
        chk({nm, " valid"}, {15'h0000, rvalid}, 16'h0001);
        chk(nm, rdata, exp);
    endtask

    task automatic wr(input logic [11:0] a, input logic [1:0] be,
                      input logic [15:0] d);
        @(negedge clk);
        req.wr    = 1'b1;
        req.addr  = a;
        req.be    = be;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
    endtask

    task automatic report_and_stop;
        if (fails == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // a hang costs far more than the hundred and fifty or so cycles the tests take
    initial
    begin
        #(40 * 3000);
        fails++;
        report_and_stop;
    end

    initial
    begin
        fr[0] = {6'b100000, 48'hffffffffffff, 16'h05dd, 12'h5dd};
        fr[1] = {6'b011100, 48'h020000000001, 16'h05dc, 12'hfff};
        fr[2] = {6'b000010, 48'h01005e000001, 16'h0600, 12'h03c};
        fr[3] = {6'b000001, 48'h020000000002, 16'h0040, 12'h040};
        fr[4] = {6'b000001, 48'h020000000002, 16'h0040, 12'h040};
        st = '{16'ha0c8, 16'h9c20, 16'h804a, 16'h0000, 16'h8021};
        bc = '{12'h5dd, 12'hfff, 12'h03c, 12'h000, 12'h040};
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 4; i++)
            rd(12'h17a + 12'(2 * i), 2'h3, 16'h0000, "reset");
        // each frame is read, poked, read again, then withdrawn
        for (int i = 0; i < 5; i++)
        begin
            frame    = fr[i];
            pass_bad = pb[i];
            present  = 1'b1;
            repeat (3) @(negedge clk);
            rd(`RFSTQ_OFS_RX_STATUS, 2'h3, st[i],
               "status");
            // the same compare also
            wr(`RFSTQ_OFS_RX_STATUS, 2'h3, 16'hffff);
            rd(`RFSTQ_OFS_RX_STATUS, 2'h3, st[i], "again");
            rd(`RFSTQ_OFS_RX_BYTES, 2'h1, {8'h00, bc[i][7:0]},
               "lo");
            rd(`RFSTQ_OFS_RX_BYTES, 2'h2, {4'h0, bc[i][11:8], 8'h00},
               "hi");
            present = 1'b0;
            repeat (2) @(negedge clk);
            rd(`RFSTQ_OFS_RX_STATUS, 2'h3, 16'h0000, "gone");
        end
        // monitor armed before room exists, room equal to request
        wr(`RFSTQ_OFS_TX_CMD, 2'h2, 16'h0103);
        rd(`RFSTQ_OFS_TX_CMD, 2'h3, 16'h0000, "lane");
        free_b = 13'h0100;
        req_b  = 13'h0200;
        wr(`RFSTQ_OFS_TX_CMD, 2'h1, 16'h0002);
        repeat (4) @(negedge clk);
        chk("early", 16'(n_evt), 16'h0000);
        free_b = 13'h0200;
        repeat (4) @(negedge clk);
        chk("event", 16'(n_evt), 16'h0001);
        wr(`RFSTQ_OFS_TX_CMD, 2'h1, 16'h0003);
        wr(`RFSTQ_OFS_TX_CMD, 2'h1, 16'h0003);
        rd(`RFSTQ_OFS_TX_CMD, 2'h3, 16'h0003, "set");
        // host waits for both bits to clear before rewriting
        for (int k = 0; k < 20 && cmd !== 2'h0; k++)
            @(negedge clk);
        chk("enqueues", 16'(n_enq), 16'h0001);
        chk("no rearm", 16'(n_evt), 16'h0001);
        rd(`RFSTQ_OFS_TX_CMD, 2'h3, 16'h0000, "cleared");
        // a write while ce is low must leave every bit alone
        ce_i = 1'b0;
        wr(`RFSTQ_OFS_TX_CMD, 2'h1, 16'h0001);
        ce_i = 1'b1;
        rd(`RFSTQ_OFS_TX_CMD, 2'h3, 16'h0000, "frozen");
        chk("frozen enq", 16'(n_enq), 16'h0001);
        // second arming with room already there
        wr(`RFSTQ_OFS_TX_CMD, 2'h1, 16'h0002);
        repeat (4) @(negedge clk);
        chk("event 2", 16'(n_evt), 16'h0002);
        report_and_stop;
    end
endmodule

`default_nettype wire
